// ==== hdl/pfc_top.sv ====
/*
 * Pad function configuration block: key-protected pad configuration
 * registers, per-pad function multiplexing, drive, pull and power
 * switch controls, and gated pad inputs toward the core.
 * Register words: the unlock key, thirteen pad config words holding
 * the 50 pad bytes four to a word, two high strength words, two GPIO data words and
 * one power switch word. Config, high strength and switch words take
 * writes only while the key is open; key and GPIO data always do.
 * Unaligned and unmapped accesses are ignored and read as zero.
 * Every pad control is registered, so a setting reaches its pad one
 * cycle after it lands in a register, and pad inputs reach the core
 * three cycles after they change. Software that wants glitch-free
 * pad changes must order its writes itself.
 * Assumes a register master on CORE_CLK with one-cycle strobes and
 * word-aligned addresses, peripheral module signals timed by
 * CORE_CLK, and pads whose inputs are asynchronous to CORE_CLK.
 */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

`include "pfc_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module pfc_top
   import pfc_pkg::*;
(
   // Clock and reset
   input  wire logic                      CORE_CLK,
   input  wire logic                      RST_N,
   // Register port
   input  wire logic [`PFC_AW-1:0]        REG_ADDR,
   input  wire logic [`PFC_DW-1:0]        REG_WDATA,
   input  wire logic                      REG_WR,
   input  wire logic                      REG_RD,
   output logic      [`PFC_DW-1:0]        REG_RDATA,
   // Peripheral side
   input  wire logic [`PFC_NPADS*8-1:0]   PERIPH_OUT,
   input  wire logic [`PFC_NPADS*8-1:0]   PERIPH_OE,
   output logic      [`PFC_NPADS-1:0]     CORE_IN,
   // Pad side
   input  wire logic [`PFC_NPADS-1:0]     PAD_IN,
   output logic      [`PFC_NPADS-1:0]     PAD_OUT,
   output logic      [`PFC_NPADS-1:0]     PAD_OE,
   output logic      [`PFC_NPADS*2-1:0]   PAD_DRIVE,
   output logic      [`PFC_NPADS-1:0]     PAD_PULLUP,
   output logic      [`PFC_NPADS-1:0]     PAD_PULLDOWN,
   output logic      [`PFC_NPADS*2-1:0]   PAD_RSEL,
   output logic      [`PFC_NPADS-1:0]     PAD_IE,
   // Power switches
   output logic                           SW_HI_A,
   output logic                           SW_HI_B,
   output logic                           SW_LO
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam int NP        = `PFC_NPADS;
   // Read views padded up to whole words
   localparam int CFG_BITS  = `PFC_DW * `PFC_CFG_WORDS;
   localparam int HALF_BITS = 2 * `PFC_DW;

   // Strap masks and decode bases as typed constants: a bit or part
   // select taken straight on a literal is not legal
   localparam logic [NP-1:0]      LIMITED_PADS = `PFC_LIMITED_MASK;
   localparam logic [NP-1:0]      I2C_PADS     = `PFC_I2C_MASK;
   localparam logic [`PFC_AW-1:0] ALT_BASE     = `PFC_ADDR_ALT;
   localparam logic [`PFC_AW-1:0] WT_BASE      = `PFC_ADDR_WT;

   pfc_state_t                s_q;
   pfc_state_t                s_d;

   // Decoded pad controls from the cells
   logic [NP-1:0]             c_out;
   logic [NP-1:0]             c_oe;
   logic [NP-1:0][1:0]        c_drive;
   logic [NP-1:0]             c_pu;
   logic [NP-1:0]             c_pd;
   logic [NP-1:0][1:0]        c_rsel;

   // Address decode
   logic                      unlocked;
   logic                      aligned;
   logic [`PFC_AW-1:0]        cfg_off;
   logic [3:0]                cfg_idx;
   logic                      hit_key;
   logic                      hit_cfg;
   logic                      hit_alt;
   logic                      hit_wt;
   logic                      hit_sw;
   logic                      upper;
   logic [`PFC_DW-1:0]        rd_word;

   // Wide views for word-wise reads
   logic [CFG_BITS-1:0]       cfg_flat;
   logic [HALF_BITS-1:0]      ds1_flat;
   logic [HALF_BITS-1:0]      wt_flat;

   // Per-pad setting fields unpacked from the state, and the pull-down pad strap
   logic [NP-1:0][2:0]        pad_function_select;
   logic [NP-1:0]             drive_strength_low_bit;
   logic [NP-1:0]             drive_strength_high_bit;
   logic [NP-1:0]             pad_pull_enable;
   logic [NP-1:0]             pad_input_enable;
   logic [NP-1:0][1:0]        pullup_resistor_select;
   logic [NP-1:0]             pulldown_pad;

   // Key and switch fields
   logic [7:0]                pad_write_key;
   logic                      high_side_switch_enable_a;
   logic                      high_side_switch_enable_b;
   logic                      low_side_switch_enable;

   // Write enables, key gate already applied
   logic                      key_we;
   logic                      cfg_we;
   logic                      alt_we;
   logic                      wt_we;
   logic                      sw_we;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   // Key and switch bits under their own names
   assign pad_write_key             = s_q.key;
   assign high_side_switch_enable_a = s_q.sw[`PFC_SW_HI_A];
   assign high_side_switch_enable_b = s_q.sw[`PFC_SW_HI_B];
   assign low_side_switch_enable    = s_q.sw[`PFC_SW_LO];

   // unlock compare; any other key value locks the gate
   assign unlocked = (pad_write_key == `PFC_UNLOCK_KEY);

   // Word accesses only; byte offsets inside a word never hit
   assign aligned  = (REG_ADDR[1:0] == 2'h0);
   assign cfg_off  = REG_ADDR - `PFC_ADDR_CFG;
   assign cfg_idx  = cfg_off[5:2];
   assign upper    = REG_ADDR[2];

   // Register selects
   assign hit_key  = aligned && (REG_ADDR == `PFC_ADDR_KEY);
   assign hit_cfg  = aligned && (REG_ADDR >= `PFC_ADDR_CFG)
                     && (cfg_off[7:2] < `PFC_CFG_WORDS);
   assign hit_alt  = aligned && (REG_ADDR[7:3] == ALT_BASE[7:3]);
   assign hit_wt   = aligned && (REG_ADDR[7:3] == WT_BASE[7:3]);
   assign hit_sw   = aligned && (REG_ADDR == `PFC_ADDR_SW);

   // Zero-extended views; nonexistent pads read as zero
   assign cfg_flat = {{(CFG_BITS - NP * 8){1'b0}}, s_q.cfg};
   assign ds1_flat = {{(HALF_BITS - NP){1'b0}}, s_q.ds1};
   assign wt_flat  = {{(HALF_BITS - NP){1'b0}}, s_q.wt};

   ////////////////////////////////////////////////////////////////////////////
   // Write enables

   // Key word, never gated
   assign key_we   = REG_WR && hit_key;
   // config words need the open key
   assign cfg_we   = REG_WR && hit_cfg && unlocked;
   // high strength words need the open key
   assign alt_we   = REG_WR && hit_alt && unlocked;
   // GPIO data word, never gated
   assign wt_we    = REG_WR && hit_wt;
   // switch word needs the open key
   // a refused write raises no flag or event
   assign sw_we    = REG_WR && hit_sw && unlocked;

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer

   // reads never depend on the key
   always_comb begin
      rd_word = '0;
      if (hit_key) begin
         rd_word = {24'h000000, pad_write_key};
      end else if (hit_cfg) begin
         rd_word = cfg_flat[cfg_idx * 32 +: 32];
      end else if (hit_alt) begin
         rd_word = ds1_flat[upper * 32 +: 32];
      end else if (hit_wt) begin
         rd_word = wt_flat[upper * 32 +: 32];
      end else if (hit_sw) begin
         rd_word = {29'h00000000, s_q.sw};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-pad decode cells

   for (genvar gp = 0; gp < NP; gp++) begin : g_pad
      // Unpack the pad byte once; the input gate reads the same names
      assign pad_function_select[gp]     = s_q.cfg[gp][`PFC_F_FSEL];
      assign drive_strength_low_bit[gp]  = s_q.cfg[gp][`PFC_F_STRNG];
      assign drive_strength_high_bit[gp] = s_q.ds1[gp];
      assign pad_pull_enable[gp]         = s_q.cfg[gp][`PFC_F_PULL];
      assign pad_input_enable[gp]        = s_q.cfg[gp][`PFC_F_IE];
      assign pullup_resistor_select[gp]  = s_q.cfg[gp][`PFC_F_RSEL];
      assign pulldown_pad[gp]            = (gp == `PFC_PULLDOWN_PAD);

      // Pure decode; its results are registered below
      pfc_pad_cell u_cell (
         .fsel         (pad_function_select[gp]),
         .strng        (drive_strength_low_bit[gp]),
         .ds1          (drive_strength_high_bit[gp]),
         .pull         (pad_pull_enable[gp]),
         .rsel_in      (pullup_resistor_select[gp]),
         .gpio_bit     (s_q.wt[gp]),
         .limited      (LIMITED_PADS[gp]),
         .pulldown_pad (pulldown_pad[gp]),
         .i2c_pad      (I2C_PADS[gp]),
         .fn_out       (PERIPH_OUT[gp * 8 +: 8]),
         .fn_oe        (PERIPH_OE[gp * 8 +: 8]),
         .out          (c_out[gp]),
         .oe           (c_oe[gp]),
         .drive        (c_drive[gp]),
         .pu           (c_pu[gp]),
         .pd           (c_pd[gp]),
         .rsel         (c_rsel[gp])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d       = s_q;
      // Read data stands for one cycle only
      s_d.rdata = '0;
      if (REG_RD) begin
         s_d.rdata = rd_word;
      end

      // Key itself is always writable, else it could never unlock
      if (key_we) begin
         s_d.key = REG_WDATA[7:0];
      end

      if (cfg_we) begin
         for (int p = 0; p < NP; p++) begin
            if (cfg_idx == 4'(p / 4)) begin
               s_d.cfg[p] = REG_WDATA[(p % 4) * 8 +: 8];
            end
         end
      end

      if (alt_we) begin
         if (upper) begin
            s_d.ds1[NP-1:32] = REG_WDATA[NP-33:0];
         end else begin
            s_d.ds1[31:0] = REG_WDATA;
         end
      end

      // GPIO data is not configuration and is never key gated
      if (wt_we) begin
         if (upper) begin
            s_d.wt[NP-1:32] = REG_WDATA[NP-33:0];
         end else begin
            s_d.wt[31:0] = REG_WDATA;
         end
      end

      if (sw_we) begin
         s_d.sw = REG_WDATA[2:0];
      end

      // Two flops before any logic reads a pad
      s_d.in_s1 = PAD_IN;
      s_d.in_s2 = s_q.in_s1;

      for (int p = 0; p < NP; p++) begin
         s_d.ie[p]      = pad_input_enable[p];
         s_d.core_in[p] = s_q.in_s2[p] & pad_input_enable[p];
      end

      // Decoded pad controls, one cycle behind the settings
      s_d.out   = c_out;
      s_d.oe    = c_oe;
      s_d.drive = c_drive;
      s_d.pu    = c_pu;
      s_d.pd    = c_pd;
      s_d.rsel  = c_rsel;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register

   // Bus side
   assign REG_RDATA    = s_q.rdata;
   // Core side, already past the synchroniser and the input gate
   assign CORE_IN      = s_q.core_in;
   // Pad data and enable
   assign PAD_OUT      = s_q.out;
   assign PAD_OE       = s_q.oe;
   // Pad drive, pulls and input enable
   assign PAD_DRIVE    = s_q.drive;
   assign PAD_PULLUP   = s_q.pu;
   assign PAD_PULLDOWN = s_q.pd;
   assign PAD_RSEL     = s_q.rsel;
   assign PAD_IE       = s_q.ie;

   assign SW_HI_A      = high_side_switch_enable_a;
   assign SW_HI_B      = high_side_switch_enable_b;
   assign SW_LO        = low_side_switch_enable;

endmodule

`default_nettype wire

// ==== hdl/pfc_regs.svh ====
/*
 * Register map, field positions and pad constants of the pad function
 * configuration block.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

// Pad count and bus widths
`define PFC_NPADS        50
`define PFC_AW           8
`define PFC_DW           32

// Byte addresses of the registers
`define PFC_ADDR_KEY     8'h00
`define PFC_ADDR_CFG     8'h04
`define PFC_CFG_WORDS    6'h0d
`define PFC_ADDR_ALT     8'h40
`define PFC_ADDR_WT      8'h50
`define PFC_ADDR_SW      8'h60

// Unlock key and reset values
`define PFC_UNLOCK_KEY   8'h73
`define PFC_KEY_RST      8'h00
`define PFC_CFG_RST      8'h00

// Fields inside one pad byte of the pad config words
`define PFC_F_PULL       0
`define PFC_F_IE         1
`define PFC_F_STRNG      2
`define PFC_F_FSEL       5:3
`define PFC_F_RSEL       7:6

// Function select value that hands the pad to the GPIO data bit
`define PFC_FSEL_GPIO    3'h3

// Bits of the switch register
`define PFC_SW_HI_A      0
`define PFC_SW_HI_B      1
`define PFC_SW_LO        2

// Pad classes
`define PFC_PULLDOWN_PAD 20
`define PFC_LIMITED_MASK 50'h20b3fc33fca58
`define PFC_I2C_MASK     50'h30d800a000363

// Drive strength codes on the pad drive bus
`define PFC_DRV_4MA      2'h1

`endif

// ==== hdl/pfc_pkg.sv ====
/*
 * Types of the pad function configuration block.
 * Assumes pfc_regs.svh is on the include path.
 */
`include "pfc_regs.svh"

package pfc_pkg;

   // Whole state of the top module, one register
   typedef struct packed {
      logic [7:0]                     key;
      logic [`PFC_NPADS-1:0][7:0]     cfg;
      logic [`PFC_NPADS-1:0]          ds1;
      logic [`PFC_NPADS-1:0]          wt;
      logic [2:0]                     sw;
      logic [`PFC_DW-1:0]             rdata;
      logic [`PFC_NPADS-1:0]          in_s1;
      logic [`PFC_NPADS-1:0]          in_s2;
      logic [`PFC_NPADS-1:0]          core_in;
      logic [`PFC_NPADS-1:0]          out;
      logic [`PFC_NPADS-1:0]          oe;
      logic [`PFC_NPADS-1:0][1:0]     drive;
      logic [`PFC_NPADS-1:0]          pu;
      logic [`PFC_NPADS-1:0]          pd;
      logic [`PFC_NPADS-1:0][1:0]     rsel;
      logic [`PFC_NPADS-1:0]          ie;
   } pfc_state_t;

endpackage

// ==== hdl/pfc_pad_cell.sv ====
/*
 * Per-pad decode: function multiplexer, drive strength, pulls and
 * I2C resistor select for one pad. Purely combinational.
 * Assumes the instantiating module registers every result.
 */
`timescale 1ns/100ps
`default_nettype none

module pfc_pad_cell (
   // Pad settings
   input  wire logic [2:0] fsel,
   input  wire logic       strng,
   input  wire logic       ds1,
   input  wire logic       pull,
   input  wire logic [1:0] rsel_in,
   input  wire logic       gpio_bit,
   // Pad class straps
   input  wire logic       limited,
   input  wire logic       pulldown_pad,
   input  wire logic       i2c_pad,
   // Module signals offered to this pad
   input  wire logic [7:0] fn_out,
   input  wire logic [7:0] fn_oe,
   // Decoded pad controls
   output logic            out,
   output logic            oe,
   output logic [1:0]      drive,
   output logic            pu,
   output logic            pd,
   output logic [1:0]      rsel
);

   // Function multiplexer
   always_comb begin
      out = fn_out[fsel];
      oe  = fn_oe[fsel];
      if (fsel == `PFC_FSEL_GPIO) begin
         out = gpio_bit;
         oe  = 1'b1;
      end
   end

   // Drive strength and pulls
   always_comb begin
      drive = {ds1, strng};
      if (limited && ds1) begin
         drive = `PFC_DRV_4MA;
      end
      pu = pull & ~pulldown_pad;
      pd = pull & pulldown_pad;
      rsel = (i2c_pad && pull) ? rsel_in : 2'h0;
   end

endmodule

`default_nettype wire

// ==== verif/pfc_pads.sv ====
/*
 * Far side of the pad block: module outputs offered to every pad, and pad levels.
 * Assumes the bench sets fn_val and pin_val at clock edges.
 */
`timescale 1ns/100ps
`default_nettype none

module pfc_pads (
   // Settings from the bench
   input  wire logic [7:0]   fn_val,
   input  wire logic [49:0]  pin_val,
   // Toward the block
   output logic      [399:0] periph_out,
   output logic      [399:0] periph_oe,
   output logic      [49:0]  pad_in
);
   // eight signals per pad, enable opposite to data so both matter
   assign periph_out = {50{fn_val}};
   assign periph_oe  = {50{~fn_val}};
   // Pads are asynchronous levels
   assign pad_in     = pin_val;
endmodule

`default_nettype wire

// ==== verif/pfc_chk.sv ====
/*
 * Assertions on the ports of the pad block.
 * Assumes one clock domain; bound into pfc_top below.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pfc_regs.svh"

module pfc_chk (
   // Clock, reset, register port
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [31:0] REG_RDATA,
   // Pad and switch outputs
   input  wire logic [49:0] CORE_IN,
   input  wire logic [49:0] PAD_IE,
   input  wire logic [99:0] PAD_DRIVE,
   input  wire logic [49:0] PAD_PULLUP,
   input  wire logic [49:0] PAD_PULLDOWN,
   input  wire logic [99:0] PAD_RSEL,
   input  wire logic        SW_HI_A,
   input  wire logic        SW_HI_B,
   input  wire logic        SW_LO
);
   localparam logic [49:0] LIM = `PFC_LIMITED_MASK;
   localparam logic [49:0] I2C = `PFC_I2C_MASK;
   logic [7:0] key_q;
   logic       bad_dr;
   logic       bad_rs;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Shadow key, tells when the gate is open
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) key_q <= 8'h00;
      else if (REG_WR && REG_ADDR == 8'h00) key_q <= REG_WDATA[7:0];
   end
   // Pad class limits, flattened to one flag each
   always_comb begin
      bad_dr = 1'b0;
      bad_rs = 1'b0;
      for (int p = 0; p < 50; p++) begin
         bad_dr |= LIM[p] & PAD_DRIVE[2*p+1];
         bad_rs |= (|PAD_RSEL[2*p+:2]) & ~(I2C[p] & PAD_PULLUP[p]);
      end
   end
   a_locked_sw: assert property (REG_WR && REG_ADDR == 8'h60 && key_q != 8'h73
      |=> $stable({SW_HI_A, SW_HI_B, SW_LO})) else $error("locked write moved switches");
   a_open_sw: assert property (REG_WR && REG_ADDR == 8'h60 && key_q == 8'h73
      |=> {SW_LO, SW_HI_B, SW_HI_A} == $past(REG_WDATA[2:0]))
      else $error("switches do not follow write");
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
      else $error("read data outside read cycle");
   a_key_read: assert property (REG_RD && REG_ADDR == 8'h00
      |=> REG_RDATA == {24'h0, $past(key_q)}) else $error("key read back wrong");
   a_input_gate: assert property ((CORE_IN & ~PAD_IE & ~$past(PAD_IE)) == 50'h0)
      else $error("input passed while disabled");
   a_pad20_up: assert property (!PAD_PULLUP[20]) else $error("pull-up on pad 20");
   a_pull_down: assert property ((PAD_PULLDOWN & ~(50'h1 << 20)) == 50'h0)
      else $error("pull-down off pad 20");
   a_drive_limit: assert property (!bad_dr) else $error("high drive on limited pad");
   a_rsel_i2c: assert property (!bad_rs) else $error("resistor select off I2C pull");
endmodule

bind pfc_top pfc_chk pfc_chk_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .CORE_IN(CORE_IN), .PAD_IE(PAD_IE), .PAD_DRIVE(PAD_DRIVE), .PAD_PULLUP(PAD_PULLUP),
   .PAD_PULLDOWN(PAD_PULLDOWN), .PAD_RSEL(PAD_RSEL), .SW_HI_A(SW_HI_A), .SW_HI_B(SW_HI_B),
   .SW_LO(SW_LO));

`default_nettype wire

// ==== verif/pfc_top_tb.sv ====
/*
 * Self-checking bench of the pad block: key gate, pad decode, switches, inputs.
 * Assumes pfc_pads as far side and pfc_chk bound into the design.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pfc_regs.svh"

module pfc_top_tb;
   localparam logic [49:0] LIM = `PFC_LIMITED_MASK;
   localparam logic [49:0] I2C = `PFC_I2C_MASK;
   logic         CORE_CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
   logic [7:0]   REG_ADDR = 8'h00, fn_val = 8'h00;
   logic [31:0]  REG_WDATA = 32'h0, REG_RDATA, d;
   logic [399:0] PERIPH_OUT, PERIPH_OE;
   logic [49:0]  CORE_IN, PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP, PAD_PULLDOWN, PAD_IE;
   logic [49:0]  pin_val = 50'h0;
   logic [99:0]  PAD_DRIVE, PAD_RSEL;
   logic         SW_HI_A, SW_HI_B, SW_LO;
   logic [7:0]   cfg_m [52];
   logic [63:0]  alt_m = 64'h0, wt_m = 64'h0;
   logic [2:0]   sw_m = 3'h0;
   int           bad_count = 0, checks_done = 0, cyc = 0;

   always #25 CORE_CLK = ~CORE_CLK;

   pfc_top pfc_top_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .PERIPH_OUT(PERIPH_OUT), .PERIPH_OE(PERIPH_OE), .CORE_IN(CORE_IN), .PAD_IN(PAD_IN),
      .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_DRIVE(PAD_DRIVE), .PAD_PULLUP(PAD_PULLUP),
      .PAD_PULLDOWN(PAD_PULLDOWN), .PAD_RSEL(PAD_RSEL), .PAD_IE(PAD_IE),
      .SW_HI_A(SW_HI_A), .SW_HI_B(SW_HI_B), .SW_LO(SW_LO));
   pfc_pads pfc_pads_inst (.fn_val(fn_val), .pin_val(pin_val), .periph_out(PERIPH_OUT),
      .periph_oe(PERIPH_OE), .pad_in(PAD_IN));

   // Verdict and end of run, the only exit
   task automatic complete_run();
      if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [99:0] e, input logic [99:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // Register port cycles, one-cycle strobes
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CORE_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= v;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge CORE_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      #1 chk("rdata", e, REG_RDATA);
   endtask
   // Expected pad controls from the settings model
   task automatic pads();
      logic [49:0] o, e, pu, pd, ie;
      logic [99:0] dr, rs;
      logic [7:0]  b;
      for (int p = 0; p < 50; p++) begin
         b = cfg_m[p];
         o[p] = (b[5:3] == 3'h3) ? wt_m[p] : fn_val[b[5:3]];
         e[p] = (b[5:3] == 3'h3) | ~fn_val[b[5:3]];
         dr[2*p+:2] = (LIM[p] & alt_m[p]) ? 2'h1 : {alt_m[p], b[2]};
         pu[p] = b[0] & (p != 20);
         pd[p] = b[0] & (p == 20);
         rs[2*p+:2] = (I2C[p] & b[0]) ? b[7:6] : 2'h0;
         ie[p] = b[1];
      end
      chk("pad_out", o, PAD_OUT);
      chk("pad_oe", e, PAD_OE);
      chk("drive", dr, PAD_DRIVE);
      chk("pullup", pu, PAD_PULLUP);
      chk("pulldown", pd, PAD_PULLDOWN);
      chk("rsel", rs, PAD_RSEL);
      chk("ie", ie, PAD_IE);
      chk("core_in", pin_val & ie, CORE_IN);
      chk("switch", sw_m, {SW_LO, SW_HI_B, SW_HI_A});
   endtask

   // Hang guard
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         complete_run();
      end
   end

   // Main sequence
   initial begin
      void'($urandom(32'hf373));
      foreach (cfg_m[i]) cfg_m[i] = 8'h00;
      repeat (3) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      rd(8'h00, 32'h0);
      wr(8'h04, 32'hffffffff);
      wr(8'h60, 32'h7);
      rd(8'h04, 32'h0);
      rd(8'h3c, 32'h0);
      wr(8'h00, 32'h73);
      rd(8'h00, 32'h73);
      for (int r = 0; r < 8; r++) begin
         @(posedge CORE_CLK);
         fn_val <= 8'($urandom);
         pin_val <= {18'($urandom), 32'($urandom)};
         for (int k = 0; k < 13; k++) begin
            d = $urandom;
            for (int i = 0; i < 4; i++) d[8*i+3+:3] = 3'((4*k + i + r) % 8);
            wr(8'(4 + 4*k), d);
            if (k == 12) d[31:16] = 16'h0;
            for (int i = 0; i < 4; i++) cfg_m[4*k+i] = d[8*i+:8];
         end
         alt_m = {14'h0, 18'($urandom), 32'($urandom)};
         wt_m = {14'h0, 18'($urandom), 32'($urandom)};
         sw_m = 3'($urandom);
         wr(8'h40, alt_m[31:0]);
         wr(8'h44, alt_m[63:32]);
         wr(8'h50, wt_m[31:0]);
         wr(8'h54, wt_m[63:32]);
         wr(8'h60, {29'h0, sw_m});
         repeat (4) @(posedge CORE_CLK);
         #1 pads();
         rd(8'h34, {16'h0, cfg_m[49], cfg_m[48]});
      end
      wr(8'h00, 32'h12);
      wr(8'h04, ~{cfg_m[3], cfg_m[2], cfg_m[1], cfg_m[0]});
      wr(8'h60, {29'h0, ~sw_m});
      wr(8'h40, ~alt_m[31:0]);
      wt_m = ~wt_m & 64'h3ffffffffffff;
      wr(8'h50, wt_m[31:0]);
      wr(8'h54, wt_m[63:32]);
      repeat (4) @(posedge CORE_CLK);
      #1 pads();
      rd(8'h04, {cfg_m[3], cfg_m[2], cfg_m[1], cfg_m[0]});
      rd(8'h40, alt_m[31:0]);
      rd(8'h44, alt_m[63:32]);
      rd(8'h54, wt_m[63:32]);
      rd(8'h60, {29'h0, sw_m});
      complete_run();
   end
endmodule

`default_nettype wire
